// >>> core/ocss_source_select.sv
// output clock source select and per-loop divider sync control
// assumes the serial configuration port delivers decoded byte requests
// Function
// R1: rising loop sync bit holds every output divider sourced from that loop in reset
// R2: falling loop sync bit releases all affected dividers together in one cycle
// R3: that release also clears coarse phase of affected outputs to zero
// R4: two sync bits, bit 4 first loop, bit 5 second loop, reset zero
// R5: outputs 0-3 one selector bit each at bits 0-3; 0 first loop, 1 second
// R6: after reset outputs 0,2 use first loop, outputs 1,3 use second loop
// R7: outputs 4-7 three-bit code: loops, outputs 2/3, references 0-2, crystal
// R8: outputs 4,6 select at bits 2:0, outputs 5,7 at bits 6:4
// R9: software must not route references above 250 MHz to outputs 4-7
// R10: after reset output 5 selects output 2
// R11: after reset output 6 selects reference 2, output 7 reference 1
// R12: software writes reserved bits zero; device stores none and reads zero
// R13: fine phase loads at sync release, which clears coarse, so set fine first
// R14: output is affected by a loop's sync bit when its selector names that loop
`timescale 1ns/1ps
module ocss_source_select
  import ocss_pkg::*;
(
  input wire logic clk, // 25 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire ocss_pkg::ocss_cfg_req_t cfgReq, // byte request from config port
  output logic [7:0] rdData, // read data, one cycle after rdEn
  output logic rdValid, // read data strobe
  output ocss_pkg::ocss_src_vec_t outSource, // source code per output
  output logic [7:0] dividerHold, // output divider held in reset
  output logic [7:0] phaseRestart, // pulse: clear coarse, load fine
  output logic [1:0] loopSyncState // current sync bits, first loop in bit 0
);
  import ocss_pkg::*;

  // ==========================================================
  // decode helpers
  function automatic logic namesLoop(input logic [2:0] code, input logic loopB);
    namesLoop = (code == (loopB ? OCSS_SRC_LOOP_B : OCSS_SRC_LOOP_A));
  endfunction

  // ==========================================================
  // registers
  logic [3:0] lowSel_reg;
  logic loopSyncA_reg;
  logic loopSyncB_reg;
  logic [2:0] out4Sel_reg;
  logic [2:0] out5Sel_reg;
  logic [2:0] out6Sel_reg;
  logic [2:0] out7Sel_reg;
  logic syncAPrev_reg;
  logic syncBPrev_reg;

  wire logic wrLow = cfgReq.wrEn && (cfgReq.addr == OCSS_ADDR_SYNC_LOW);
  wire logic wr45 = cfgReq.wrEn && (cfgReq.addr == OCSS_ADDR_SEL45);
  wire logic wr67 = cfgReq.wrEn && (cfgReq.addr == OCSS_ADDR_SEL67);
  wire logic [3:0] lowSel_next = cfgReq.wrData[OCSS_LOW_SEL_LSB +: OCSS_NUM_LOW];
  wire logic [2:0] evenSel_next = cfgReq.wrData[OCSS_EVEN_SEL_LSB +: OCSS_SEL_W];
  wire logic [2:0] oddSel_next = cfgReq.wrData[OCSS_ODD_SEL_LSB +: OCSS_SEL_W];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lowSel_reg <= OCSS_RST_LOW_SEL; // see R6
      loopSyncA_reg <= 1'b0; // see R4
      loopSyncB_reg <= 1'b0; // see R4
    end else if (wrLow) begin
      lowSel_reg <= lowSel_next; // see R5
      loopSyncA_reg <= cfgReq.wrData[OCSS_SYNC_A_BIT]; // see R4
      loopSyncB_reg <= cfgReq.wrData[OCSS_SYNC_B_BIT]; // see R4
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out4Sel_reg <= OCSS_RST_SEL4;
      out5Sel_reg <= OCSS_RST_SEL5; // see R10
    end else if (wr45) begin
      out4Sel_reg <= evenSel_next; // see R8
      out5Sel_reg <= oddSel_next; // see R8
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out6Sel_reg <= OCSS_RST_SEL6; // see R11
      out7Sel_reg <= OCSS_RST_SEL7; // see R11
    end else if (wr67) begin
      out6Sel_reg <= evenSel_next; // see R8
      out7Sel_reg <= oddSel_next; // see R8
    end
  end

  // ==========================================================
  // per-output source codes, low outputs widened to loop codes
  wire ocss_src_vec_t srcVec;
  genvar gi;
  generate
    for (gi = 0; gi < OCSS_NUM_LOW; gi++) begin : g_low
      assign srcVec[gi] = lowSel_reg[gi] ? OCSS_SRC_LOOP_B : OCSS_SRC_LOOP_A; // see R5
    end
  endgenerate
  assign srcVec[4] = out4Sel_reg; // see R7
  assign srcVec[5] = out5Sel_reg; // see R7
  assign srcVec[6] = out6Sel_reg; // see R7
  assign srcVec[7] = out7Sel_reg; // see R7

  // ==========================================================
  // sync edges and affected outputs
  wire logic [7:0] affA;
  wire logic [7:0] affB;
  generate
    for (gi = 0; gi < OCSS_NUM_OUT; gi++) begin : g_aff
      assign affA[gi] = namesLoop(srcVec[gi], 1'b0); // see R14
      assign affB[gi] = namesLoop(srcVec[gi], 1'b1); // see R14
    end
  endgenerate

  wire logic fallA = syncAPrev_reg && !loopSyncA_reg;
  wire logic fallB = syncBPrev_reg && !loopSyncB_reg;
  // hold follows the level, so all dividers of a loop leave reset together
  wire logic [7:0] hold_next = ({8{loopSyncA_reg}} & affA)
                             | ({8{loopSyncB_reg}} & affB); // see R1 see R2
  // released outputs restart with coarse cleared and fine loaded
  wire logic [7:0] restart_next = ({8{fallA}} & affA)
                                | ({8{fallB}} & affB); // see R3 see R13

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncAPrev_reg <= 1'b0;
      syncBPrev_reg <= 1'b0;
      dividerHold <= 8'h00;
      phaseRestart <= 8'h00;
    end else begin
      syncAPrev_reg <= loopSyncA_reg;
      syncBPrev_reg <= loopSyncB_reg;
      dividerHold <= hold_next; // see R1 see R2
      phaseRestart <= restart_next; // see R3
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      outSource <= {OCSS_RST_SEL7, OCSS_RST_SEL6, OCSS_RST_SEL5, OCSS_RST_SEL4,
                    OCSS_SRC_LOOP_B, OCSS_SRC_LOOP_A, OCSS_SRC_LOOP_B, OCSS_SRC_LOOP_A}; // see R6
      loopSyncState <= 2'h0;
    end else begin
      outSource <= srcVec;
      loopSyncState <= {loopSyncB_reg, loopSyncA_reg};
    end
  end

  // ==========================================================
  // read path, reserved bits and unmapped offsets read zero
  logic [7:0] rd_next;
  always_comb begin
    rd_next = 8'h00;
    case (cfgReq.addr)
      OCSS_ADDR_SYNC_LOW: begin
        rd_next[OCSS_LOW_SEL_LSB +: OCSS_NUM_LOW] = lowSel_reg;
        rd_next[OCSS_SYNC_A_BIT] = loopSyncA_reg;
        rd_next[OCSS_SYNC_B_BIT] = loopSyncB_reg;
      end
      OCSS_ADDR_SEL45: begin
        rd_next[OCSS_EVEN_SEL_LSB +: OCSS_SEL_W] = out4Sel_reg;
        rd_next[OCSS_ODD_SEL_LSB +: OCSS_SEL_W] = out5Sel_reg;
      end
      OCSS_ADDR_SEL67: begin
        rd_next[OCSS_EVEN_SEL_LSB +: OCSS_SEL_W] = out6Sel_reg;
        rd_next[OCSS_ODD_SEL_LSB +: OCSS_SEL_W] = out7Sel_reg;
      end
      default: begin
        rd_next = 8'h00; // see R12
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= 8'h00;
      rdValid <= 1'b0;
    end else begin
      rdData <= cfgReq.rdEn ? rd_next : 8'h00;
      rdValid <= cfgReq.rdEn;
    end
  end

  // ==========================================================
  // checks
  logic firstCycle_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      firstCycle_reg <= 1'b1;
    end else begin
      firstCycle_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_hold_on_rise: assert property ( // see R1
    $rose(loopSyncA_reg) |=> ((dividerHold & $past(affA)) == $past(affA)))
    else $error("loop a sync rise did not hold affected dividers");

  a_release_together: assert property ( // see R2
    ($fell(loopSyncA_reg) && !loopSyncB_reg) |=> (dividerHold == 8'h00))
    else $error("dividers not released together");

  a_coarse_clear: assert property ( // see R3
    $fell(loopSyncB_reg) |=> ((phaseRestart & $past(affB)) == $past(affB)))
    else $error("coarse phase not cleared on release");

  a_sync_bit_place: assert property ( // see R4
    wrLow |=> (loopSyncB_reg == $past(cfgReq.wrData[OCSS_SYNC_B_BIT])))
    else $error("sync bit stored from wrong position");

  a_low_sel_map: assert property ( // see R5
    ##1 (outSource[1] == ($past(lowSel_reg[1]) ? 3'h1 : 3'h0)))
    else $error("low output source mismatch");

  a_reset_sources: assert property ( // see R6
    firstCycle_reg |-> (outSource[0] == 3'h0 && outSource[1] == 3'h1
                        && outSource[5] == 3'h2 && outSource[6] == 3'h6
                        && outSource[7] == 3'h5))
    else $error("reset source selection wrong");

  a_high_decode: assert property ( // see R7
    (out6Sel_reg == 3'h1 && loopSyncB_reg && !loopSyncA_reg) |=> dividerHold[6])
    else $error("output 6 not held by second loop sync");

  a_high_not_loop: assert property ( // see R14
    (out7Sel_reg == 3'h7) |=> !dividerHold[7])
    else $error("crystal-fed output held by sync");

  a_field_place: assert property ( // see R8
    wr67 |=> ##1 (outSource[7] == $past(cfgReq.wrData[6:4], 2)))
    else $error("output 7 selector from wrong bits");

  a_rsvd_read: assert property ( // see R12
    (cfgReq.rdEn && cfgReq.addr == OCSS_ADDR_SYNC_LOW) |=> (rdValid && rdData[7:6] == 2'h0))
    else $error("reserved bits read nonzero");

  // ==========================================================
  // sync, hold and restart checks

  a_hold_b_rise: assert property ( // see R1
    $rose(loopSyncB_reg) |=> ((dividerHold & $past(affB)) == $past(affB)))
    else $error("loop b sync rise did not hold affected dividers");

  a_release_b: assert property ( // see R2
    ($fell(loopSyncB_reg) && !loopSyncA_reg) |=> (dividerHold == 8'h00))
    else $error("loop b dividers not released together");

  a_coarse_clear_a: assert property ( // see R3
    $fell(loopSyncA_reg) |=> ((phaseRestart & $past(affA)) == $past(affA)))
    else $error("loop a release did not clear coarse phase");

  a_restart_on_fall: assert property ( // see R3
    (!$fell(loopSyncA_reg) && !$fell(loopSyncB_reg)) |=> (phaseRestart == 8'h00))
    else $error("restart pulse without a sync release");

  a_sync_a_place: assert property ( // see R4
    wrLow |=> (loopSyncA_reg == $past(cfgReq.wrData[OCSS_SYNC_A_BIT])))
    else $error("first loop sync bit stored from wrong position");

  a_sync_state: assert property ( // see R4
    ##1 (loopSyncState == $past({loopSyncB_reg, loopSyncA_reg})))
    else $error("sync state output does not follow sync bits");

  a_out2_fed_free: assert property ( // see R14
    (out4Sel_reg == OCSS_SRC_OUT2) |=> !dividerHold[4])
    else $error("output fed from output 2 held by sync");

  // ==========================================================
  // selector and register access checks

  a_low_out0: assert property ( // see R5
    ##1 (outSource[0] == ($past(lowSel_reg[0]) ? OCSS_SRC_LOOP_B : OCSS_SRC_LOOP_A)))
    else $error("output 0 source mismatch");

  a_rst_low_pick: assert property ( // see R6
    firstCycle_reg |-> (outSource[2] == OCSS_SRC_LOOP_A && outSource[3] == OCSS_SRC_LOOP_B
                        && outSource[4] == OCSS_RST_SEL4))
    else $error("reset source of outputs 2 to 4 wrong");

  a_rst_high_pick: assert property ( // see R10 see R11
    firstCycle_reg |-> (out5Sel_reg == OCSS_SRC_OUT2 && out6Sel_reg == OCSS_SRC_REF2
                        && out7Sel_reg == OCSS_SRC_REF1))
    else $error("reset selectors of outputs 5 to 7 wrong");

  a_out4_field: assert property ( // see R8
    wr45 |=> ##1 (outSource[4] == $past(cfgReq.wrData[OCSS_EVEN_SEL_LSB +: OCSS_SEL_W], 2)))
    else $error("output 4 selector from wrong bits");

  a_out6_field: assert property ( // see R8
    wr67 |=> ##1 (outSource[6] == $past(cfgReq.wrData[OCSS_EVEN_SEL_LSB +: OCSS_SEL_W], 2)))
    else $error("output 6 selector from wrong bits");

  a_rsvd_offset: assert property ( // see R12
    (cfgReq.rdEn && cfgReq.addr == OCSS_ADDR_RSVD) |=> (rdValid && rdData == 8'h00))
    else $error("reserved offset read nonzero");

  a_rsvd_write: assert property ( // see R12
    (cfgReq.wrEn && cfgReq.addr == OCSS_ADDR_RSVD) |=> ($stable(lowSel_reg)
      && $stable(loopSyncA_reg) && $stable(loopSyncB_reg) && $stable(out4Sel_reg)
      && $stable(out5Sel_reg) && $stable(out6Sel_reg) && $stable(out7Sel_reg)))
    else $error("write to reserved offset changed a register");

endmodule

// >>> include/ocss_pkg.sv
// output clock source select: shared constants and carrier types
// assumes byte-wide register access at the configuration port offsets
package ocss_pkg;
  // ==========================================================
  // sizes
  localparam int OCSS_NUM_OUT = 8;
  localparam int OCSS_NUM_LOW = 4;
  localparam int OCSS_SEL_W = 3;
  localparam int OCSS_ADDR_W = 8;
  localparam int OCSS_DATA_W = 8;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OCSS_ADDR_SYNC_LOW = 8'ha8;
  localparam logic [7:0] OCSS_ADDR_SEL45 = 8'ha9;
  localparam logic [7:0] OCSS_ADDR_SEL67 = 8'haa;
  localparam logic [7:0] OCSS_ADDR_RSVD = 8'hab;
  // ==========================================================
  // field positions
  localparam int OCSS_LOW_SEL_LSB = 0;
  localparam int OCSS_SYNC_A_BIT = 4;
  localparam int OCSS_SYNC_B_BIT = 5;
  localparam int OCSS_EVEN_SEL_LSB = 0;
  localparam int OCSS_ODD_SEL_LSB = 4;
  // ==========================================================
  // reset values
  localparam logic [3:0] OCSS_RST_LOW_SEL = 4'ha;
  localparam logic [2:0] OCSS_RST_SEL4 = 3'h0;
  localparam logic [2:0] OCSS_RST_SEL5 = 3'h2;
  localparam logic [2:0] OCSS_RST_SEL6 = 3'h6;
  localparam logic [2:0] OCSS_RST_SEL7 = 3'h5;
  // ==========================================================
  // source codes shared by all outputs
  typedef enum logic [2:0] {
    OCSS_SRC_LOOP_A = 3'h0,
    OCSS_SRC_LOOP_B = 3'h1,
    OCSS_SRC_OUT2 = 3'h2,
    OCSS_SRC_OUT3 = 3'h3,
    OCSS_SRC_REF0 = 3'h4,
    OCSS_SRC_REF1 = 3'h5,
    OCSS_SRC_REF2 = 3'h6,
    OCSS_SRC_XTAL = 3'h7
  } ocss_src_t;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } ocss_cfg_req_t;
  typedef logic [7:0][2:0] ocss_src_vec_t;
endpackage

// >>> test/ocss_testbench.sv
// testbench for the output clock source select block
// assumes ocss_pkg is compiled first and the design answers byte requests on cfgReq
`timescale 1ns/1ps
module testbench;
  import ocss_pkg::*;
  // ==========================================================
  // signals and instance
  localparam ocss_src_vec_t RST_SRC = {3'h5, 3'h6, 3'h2, 3'h0, 3'h1, 3'h0, 3'h1, 3'h0};
  logic clk;
  logic rstn;
  ocss_cfg_req_t cfgReq;
  logic [7:0] rdData;
  logic rdValid;
  ocss_src_vec_t outSource;
  logic [7:0] dividerHold;
  logic [7:0] phaseRestart;
  logic [1:0] loopSyncState;
  int n_mismatch;
  int n_tests;
  ocss_source_select u_dut (.clk(clk), .rstn(rstn), .cfgReq(cfgReq), .rdData(rdData),
    .rdValid(rdValid), .outSource(outSource), .dividerHold(dividerHold),
    .phaseRestart(phaseRestart), .loopSyncState(loopSyncState));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================
  // access and compare tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    cfgReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: addr, wrData: data};
    @(posedge clk);
    cfgReq <= '0;
  endtask
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk);
    cfgReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: addr, wrData: 8'h00};
    @(posedge clk);
    cfgReq <= '0;
    #1;
    for (int i = 0; i < 3 && rdValid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("rdValid", 8'h01, {7'h00, rdValid});
    chk("rdData", exp, rdData);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // holds and sync state after a settled write
  task automatic chk_hold(input logic [7:0] hold, input logic [1:0] sync);
    settle();
    chk("dividerHold", hold, dividerHold);
    chk("loopSyncState", {6'h00, sync}, {6'h00, loopSyncState});
  endtask
  // restart pulse after a sync clear, one cycle wide
  task automatic pulse(input logic [7:0] exp);
    #1;
    for (int i = 0; i < 4 && phaseRestart === 8'h00; i++) begin
      @(posedge clk);
      #1;
    end
    chk("phaseRestart", exp, phaseRestart);
    @(posedge clk);
    #1;
    chk("phaseRestart end", 8'h00, phaseRestart);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    $display("watchdog expired");
    print_verdict();
  end
  // ==========================================================
  // tests
  initial begin
    rstn = 1'b0;
    cfgReq = '0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    settle();
    for (int k = 0; k < 8; k++) begin
      chk("outSource", {5'h00, RST_SRC[k]}, {5'h00, outSource[k]});
    end
    chk_hold(8'h00, 2'b00);
    rd(8'ha8, 8'h0a);
    rd(8'ha9, 8'h20);
    rd(8'haa, 8'h56);
    $display("test reset values done");
    wr(8'hab, 8'hff);
    wr(8'ha9, 8'hff);
    wr(8'ha8, 8'hc0);
    rd(8'hab, 8'h00);
    rd(8'ha9, 8'h77);
    rd(8'ha8, 8'h00);
    rd(8'h00, 8'h00);
    $display("test reserved bits done");
    wr(8'ha9, 8'h10);
    wr(8'haa, 8'h00);
    wr(8'ha8, 8'h1a);
    chk_hold(8'hd5, 2'b01);
    wr(8'haa, 8'h10);
    chk_hold(8'h55, 2'b01);
    wr(8'ha8, 8'h0a);
    pulse(8'h55);
    chk("dividerHold", 8'h00, dividerHold);
    wr(8'ha8, 8'h2a);
    chk_hold(8'haa, 2'b10);
    wr(8'ha8, 8'h0a);
    pulse(8'haa);
    wr(8'ha8, 8'h3a);
    chk_hold(8'hff, 2'b11);
    wr(8'ha8, 8'h2a);
    pulse(8'h55);
    chk("dividerHold", 8'haa, dividerHold);
    wr(8'ha8, 8'h0a);
    pulse(8'haa);
    $display("test loop sync done");
    // output 4 fed from output 2, output 6 from second loop, output 7 crystal
    wr(8'ha9, 8'h12);
    wr(8'haa, 8'h71);
    wr(8'ha8, 8'h2a);
    chk_hold(8'h6a, 2'b10);
    wr(8'ha8, 8'h0a);
    pulse(8'h6a);
    wr(8'ha8, 8'h3a);
    chk_hold(8'h6f, 2'b11);
    // reset in mid-run with both sync bits set
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk_hold(8'h00, 2'b00);
    chk("phaseRestart", 8'h00, phaseRestart);
    for (int k = 0; k < 8; k++) begin
      chk("outSource", {5'h00, RST_SRC[k]}, {5'h00, outSource[k]});
    end
    $display("test indirect sources and reset done");
    wr(8'ha8, 8'h05);
    settle();
    for (int k = 0; k < 4; k++) begin
      chk("low pick", {7'h00, k[0] == 1'b0}, {5'h00, outSource[k]});
    end
    for (int i = 0; i < 8; i++) begin
      logic [2:0] c;
      c = i[2:0];
      // reference codes assume inputs within the direct routing limit
      wr(8'haa, {1'b0, c, 1'b0, c});
      wr(8'ha9, {1'b0, c, 1'b0, ~c});
      settle();
      chk("out4", {5'h00, ~c}, {5'h00, outSource[4]});
      chk("out5", {5'h00, c}, {5'h00, outSource[5]});
      chk("out6", {5'h00, c}, {5'h00, outSource[6]});
      chk("out7", {5'h00, c}, {5'h00, outSource[7]});
      rd(8'haa, {1'b0, c, 1'b0, c});
    end
    $display("test source codes done");
    print_verdict();
  end
endmodule
